// ===== src/pm_misc_regs.sv
// AXI4-Lite bank: power-management extension and misc configuration
//
// Overview of operation
// - Extension register at 4Ah is read-only and always reads zero.
// - Power data and bridge extension fields of it both read zero.
// - Misc register at F0h resets to 00002400h; reserved bits read zero.
// - Misc bit 3 is a spare writable bit that resets to zero.
// - Misc bits 15, 13, 10 drive the capability register fields.
// - Wake-from-D2 and D2 bits reset to one; software may clear them.
// - Capability bits survive bus reset; only power-on resets them.
// - Bit 4 set returns indeterminate data instead of target abort.
// - Bit 2 set keeps the link-side clock ungated.
// - Bit 1 set keeps the bus clock ungated.
// - Bit 0 set keeps the bus clock running; clear lets it stop.
// - Capability wake field defaults 1100b; bit 13 follows wake_from_d2.
//
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
`include "pm_misc_consts.svh"
module pm_misc_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic por_n,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_idle,
  input wire logic bus_idle,
  output logic wake_from_cold_prog,
  output logic wake_from_d2_prog,
  output logic d2_state_prog,
  output logic [3:0] cap_wake_field,
  output logic abort_suppress,
  output logic link_clk_en,
  output logic bus_clk_en,
  output logic clkrun_stop_ok
);
  pm_misc_pkg::wr_state_t wr_state_reg;
  pm_misc_pkg::rd_state_t rd_state_reg;
  logic [7:0] awaddr_reg;
  logic aw_held_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic w_held_reg;
  logic [4:0] ctl_reg;
  logic [31:0] misc_view;
  logic [31:0] misc_merged;
  logic wr_fire;
  logic [31:0] rdata_next;
  logic [1:0] rresp_next;

  cfg_sticky_if st();

  sticky_cap_bits u_sticky (
    .aclk(aclk),
    .por_n(por_n),
    .st(st)
  );

  clock_gate_ctl u_gate (
    .aclk(aclk),
    .aresetn(aresetn),
    .link_clock_gate_off(ctl_reg[`BIT_LINK_GATE_OFF]),
    .bus_clock_gate_off(ctl_reg[`BIT_BUS_GATE_OFF]),
    .keep_clk(ctl_reg[`BIT_KEEP_CLK]),
    .link_idle(link_idle),
    .bus_idle(bus_idle),
    .link_clk_en(link_clk_en),
    .bus_clk_en(bus_clk_en),
    .clkrun_stop_ok(clkrun_stop_ok)
  );

  // Word address of the decode, byte offsets ignored
  function automatic logic [7:0] word_of(input logic [7:0] a);
    word_of = {a[7:2], 2'h0};
  endfunction : word_of

  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  always_comb begin
    misc_view = 32'h00000000;
    misc_view[`BIT_WAKE_COLD] = st.cur_val[2];
    misc_view[`BIT_WAKE_D2] = st.cur_val[1];
    misc_view[`BIT_D2_STATE] = st.cur_val[0];
    misc_view[4:0] = ctl_reg;
  end

  // Only writable bits take the strobed data
  assign misc_merged = (misc_view & ~(strb_mask(wstrb_reg)
    & `MISC_WR_MASK)) | (wdata_reg & strb_mask(wstrb_reg)
    & `MISC_WR_MASK);

  assign s_axi_awready = (wr_state_reg == pm_misc_pkg::WR_IDLE)
    & ~aw_held_reg;
  assign s_axi_wready = (wr_state_reg == pm_misc_pkg::WR_IDLE)
    & ~w_held_reg;
  assign wr_fire = (wr_state_reg == pm_misc_pkg::WR_IDLE)
    & aw_held_reg & w_held_reg;
  assign s_axi_arready = (rd_state_reg == pm_misc_pkg::RD_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_reg <= 1'b1;
      awaddr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_reg <= 1'b0;
      wdata_reg <= 32'h00000000;
      wstrb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_reg <= 1'b1;
      wdata_reg <= s_axi_wdata;
      wstrb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_reg <= pm_misc_pkg::WR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else begin
      case (wr_state_reg)
        pm_misc_pkg::WR_IDLE: begin
          if (wr_fire) begin
            wr_state_reg <= pm_misc_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            // Extension word and capability word are mapped, writes dropped
            if (word_of(awaddr_reg) == `MISC_OFFSET ||
                word_of(awaddr_reg) == `PMX_WORD_ADDR ||
                word_of(awaddr_reg) == `CAP_OFFSET) begin
              s_axi_bresp <= `RESP_OKAY;
            end else begin
              s_axi_bresp <= `RESP_SLVERR;
            end
          end
        end
        pm_misc_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_reg <= pm_misc_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        default: begin
          wr_state_reg <= pm_misc_pkg::WR_IDLE;
          s_axi_bvalid <= 1'b0;
        end
      endcase
    end
  end

  // Bus-reset bits of the misc register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctl_reg <= 5'(`MISC_RESET);
    end else if (wr_fire && word_of(awaddr_reg) == `MISC_OFFSET) begin
      ctl_reg <= misc_merged[4:0];
    end
  end

  assign st.wr_en = wr_fire && word_of(awaddr_reg) == `MISC_OFFSET;
  assign st.wr_val = {misc_merged[`BIT_WAKE_COLD],
    misc_merged[`BIT_WAKE_D2], misc_merged[`BIT_D2_STATE]};

  assign wake_from_cold_prog = st.cur_val[2];
  assign wake_from_d2_prog = st.cur_val[1];
  assign d2_state_prog = st.cur_val[0];
  // Only bit 13 is programmable; D3hot wake stays advertised
  assign cap_wake_field = (`CAP_WAKE_DEFAULT & 4'hB) |
    {1'b0, st.cur_val[1], 2'h0};
  assign abort_suppress = ctl_reg[`BIT_ABORT_OFF];

  always_comb begin
    rdata_next = 32'h00000000;
    rresp_next = `RESP_OKAY;
    case (word_of(s_axi_araddr))
      `MISC_OFFSET: rdata_next = misc_view;
      // Extension sits in the upper half of its word
      `PMX_WORD_ADDR: rdata_next = {`PMX_RESET, 16'h0000};
      `CAP_OFFSET: begin
        rdata_next = 32'h00000000;
        rdata_next[31] = st.cur_val[2];
        rdata_next[30:27] = cap_wake_field;
        rdata_next[26] = st.cur_val[0];
      end
      default: begin
        rresp_next = `RESP_SLVERR;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_reg <= pm_misc_pkg::RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `RESP_OKAY;
    end else begin
      case (rd_state_reg)
        pm_misc_pkg::RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_state_reg <= pm_misc_pkg::RD_RESP;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdata_next;
            s_axi_rresp <= rresp_next;
          end
        end
        pm_misc_pkg::RD_RESP: begin
          if (s_axi_rready) begin
            rd_state_reg <= pm_misc_pkg::RD_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          rd_state_reg <= pm_misc_pkg::RD_IDLE;
          s_axi_rvalid <= 1'b0;
        end
      endcase
    end
  end

  // Prot and awaddr low bits carry no meaning here
  logic unused_ok;
  assign unused_ok = ^{s_axi_awprot, s_axi_arprot};
endmodule : pm_misc_regs
`default_nettype wire

// ===== common/pm_misc_consts.svh
// Offsets, field positions, reset values of the power/misc register bank
`ifndef PM_MISC_CONSTS_SVH
`define PM_MISC_CONSTS_SVH
`define PMX_OFFSET 8'h4A
`define PMX_WORD_ADDR 8'h48
`define PMX_RESET 16'h0000
`define MISC_OFFSET 8'hF0
`define MISC_RESET 32'h00002400
`define MISC_WR_MASK 32'h0000A41F
`define CAP_OFFSET 8'h44
`define BIT_WAKE_COLD 15
`define BIT_WAKE_D2 13
`define BIT_D2_STATE 10
`define BIT_ABORT_OFF 4
`define BIT_SPARE 3
`define BIT_LINK_GATE_OFF 2
`define BIT_BUS_GATE_OFF 1
`define BIT_KEEP_CLK 0
`define CAP_WAKE_DEFAULT 4'hC
`define STICKY_RESET 3'h3
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== common/pm_misc_pkg.sv
// Types shared by the register bank modules
package pm_misc_pkg;
  typedef enum logic [1:0] {
    WR_IDLE = 2'h0,
    WR_RESP = 2'h1
  } wr_state_t;
  typedef enum logic [1:0] {
    RD_IDLE = 2'h0,
    RD_RESP = 2'h1
  } rd_state_t;
endpackage : pm_misc_pkg

// ===== common/cfg_sticky_if.sv
// Carrier for the sticky capability bits between top and holder
`timescale 1ns/1ps
`default_nettype none
interface cfg_sticky_if;
  logic wr_en;
  logic [2:0] wr_val;
  logic [2:0] cur_val;
  modport owner(input wr_en, input wr_val, output cur_val);
  modport user(output wr_en, output wr_val, input cur_val);
endinterface : cfg_sticky_if
`default_nettype wire

// ===== src/sticky_cap_bits.sv
// Capability bits that survive bus reset, reset only at power-on
`timescale 1ns/1ps
`default_nettype none
`include "pm_misc_consts.svh"
module sticky_cap_bits (
  input wire logic aclk,
  input wire logic por_n,
  cfg_sticky_if.owner st
);
  // Order: wake_from_cold, wake_from_d2, d2_state
  logic [2:0] sticky_reg;
  always_ff @(posedge aclk) begin
    if (!por_n) begin
      sticky_reg <= `STICKY_RESET;
    end else if (st.wr_en) begin
      sticky_reg <= st.wr_val;
    end
  end
  assign st.cur_val = sticky_reg;
endmodule : sticky_cap_bits
`default_nettype wire

// ===== src/clock_gate_ctl.sv
// Decides whether the internal bus and link clocks may be gated
`timescale 1ns/1ps
`default_nettype none
module clock_gate_ctl (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic link_clock_gate_off,
  input wire logic bus_clock_gate_off,
  input wire logic keep_clk,
  input wire logic link_idle,
  input wire logic bus_idle,
  output logic link_clk_en,
  output logic bus_clk_en,
  output logic clkrun_stop_ok
);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_clk_en <= 1'b1;
    end else begin
      link_clk_en <= link_clock_gate_off | ~link_idle;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_clk_en <= 1'b1;
    end else begin
      bus_clk_en <= bus_clock_gate_off | ~bus_idle;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clkrun_stop_ok <= 1'b0;
    end else begin
      clkrun_stop_ok <= ~keep_clk & bus_idle;
    end
  end
endmodule : clock_gate_ctl
`default_nettype wire

// ===== test/pm_misc_regs_properties.sv
// Port-level checks for the power/misc register bank
`timescale 1ns/1ps
`default_nettype none
module pm_misc_regs_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic link_idle,
  input wire logic bus_idle,
  input wire logic wake_from_d2_prog,
  input wire logic [3:0] cap_wake_field,
  input wire logic link_clk_en,
  input wire logic bus_clk_en,
  input wire logic clkrun_stop_ok
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire logic ar_take = s_axi_arvalid && s_axi_arready;
  wire logic rd_ext = ar_take && s_axi_araddr == 8'h48;
  wire logic rd_misc = ar_take && s_axi_araddr == 8'hF0;
  a_ext_zero: assert property (
    rd_ext |=> s_axi_rdata[31:16] == 16'h0000) else $error("ext not zero");
  a_misc_reserved: assert property (
    rd_misc |=> (s_axi_rdata & 32'hFFFF5BE0) == 32'h0) else $error("rsvd");
  a_read_answer: assert property (
    ar_take |=> s_axi_rvalid) else $error("late read data");
  a_read_done: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("rvalid");
  a_cap_follow: assert property (
    cap_wake_field == {1'b1, wake_from_d2_prog, 2'b00}) else $error("cap");
  a_link_ungated: assert property (
    !link_idle |=> link_clk_en) else $error("link clock gated");
  a_bus_ungated: assert property (
    !bus_idle |=> bus_clk_en) else $error("bus clock gated");
  a_stop_idle: assert property (
    !bus_idle |=> !clkrun_stop_ok) else $error("stop while busy");
endmodule : pm_misc_regs_properties
`default_nettype wire

// ===== test/host_cfg_master.sv
// Host-side master for the AXI4-Lite configuration port
`timescale 1ns/1ps
`default_nettype none
module host_cfg_master (
  input wire logic aclk,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
    {s_axi_rready, s_axi_awprot, s_axi_arprot, s_axi_wstrb} = 11'h000;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [1:0] r);
    logic aw_ok = 1'b0;
    logic w_ok = 1'b0;
    @(posedge aclk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, s};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    // Each channel released on its own handshake
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      aw_ok = aw_ok | s_axi_awready;
      w_ok = w_ok | s_axi_wready;
      {s_axi_awvalid, s_axi_wvalid} <= {!aw_ok, !w_ok};
    end
    @(posedge aclk);
    while (!s_axi_bvalid) @(posedge aclk);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
      output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    @(posedge aclk);
    while (!s_axi_arready) @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    @(posedge aclk);
    while (!s_axi_rvalid) @(posedge aclk);
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask : rd
endmodule : host_cfg_master
`default_nettype wire

// ===== test/pm_misc_regs_test.sv
// Bench for the power/misc configuration register bank
`timescale 1ns/1ps
`default_nettype none
module pm_misc_regs_test;
  logic aclk = 1'b0, aresetn = 1'b0, por_n = 1'b0;
  logic link_idle = 1'b0, bus_idle = 1'b0;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
  logic [3:0] s_axi_wstrb, cap_wake_field;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, wake_from_cold_prog, abort_suppress;
  logic wake_from_d2_prog, d2_state_prog, clkrun_stop_ok;
  logic link_clk_en, bus_clk_en;
  int fail_count = 0, cmp_count = 0;
  wire logic [6:0] pins = {wake_from_cold_prog, wake_from_d2_prog,
    d2_state_prog, abort_suppress, link_clk_en, bus_clk_en, clkrun_stop_ok};
  always #5 aclk = ~aclk;
  pm_misc_regs dut_u (.*);
  host_cfg_master host_u (.*);
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, e);
    host_u.rd(a, rd_val, rsp);
    chk(rd_val & m, e);
    chk({30'h0, rsp}, 32'h00000000);
  endtask : rchk
  // Cold reset also pulls power-on; warm one leaves sticky bits alone
  task automatic reset_for(input logic cold);
    @(posedge aclk);
    {aresetn, por_n} <= {1'b0, !cold};
    repeat (3) @(posedge aclk);
    {aresetn, por_n} <= 2'h3;
  endtask : reset_for
  task automatic t_defaults();
    rchk(8'hF0, 32'hFFFFFFFF, 32'h00002400);
    rchk(8'h48, 32'hFFFF0000, 32'h00000000);
    rchk(8'h44, 32'hFFFFFFFF, 32'h64000000);
    chk({25'h0, pins}, 32'h00000036);
    chk({28'h0, cap_wake_field}, 32'h0000000C);
  endtask : t_defaults
  task automatic t_writes();
    host_u.wr(8'hF0, 32'hFFFFFFFF, 4'hF, rsp);
    host_u.wr(8'h48, 32'hFFFFFFFF, 4'hF, rsp);
    chk({30'h0, rsp}, 32'h00000000);
    rchk(8'hF0, 32'hFFFFFFFF, 32'h0000A41F);
    rchk(8'h48, 32'hFFFF0000, 32'h00000000);
    rchk(8'h44, 32'hFFFFFFFF, 32'hE4000000);
    chk({25'h0, pins}, 32'h0000007E);
    host_u.wr(8'h10, 32'h00000000, 4'hF, rsp);
    chk({30'h0, rsp}, 32'h00000002);
    host_u.rd(8'h10, rd_val, rsp);
    chk({30'h0, rsp}, 32'h00000002);
  endtask : t_writes
  task automatic t_resets();
    reset_for(1'b0);
    rchk(8'hF0, 32'hFFFFFFFF, 32'h0000A400);
    host_u.wr(8'hF0, 32'h00000000, 4'hF, rsp);
    rchk(8'h44, 32'hFFFFFFFF, 32'h40000000);
    chk({25'h0, pins}, 32'h00000006);
    chk({28'h0, cap_wake_field}, 32'h00000008);
    reset_for(1'b1);
    rchk(8'hF0, 32'hFFFFFFFF, 32'h00002400);
  endtask : t_resets
  task automatic t_gates();
    {link_idle, bus_idle} <= 2'h3;
    repeat (2) @(posedge aclk);
    #1 chk({25'h0, pins}, 32'h00000031);
    host_u.wr(8'hF0, 32'h00002417, 4'hF, rsp);
    repeat (2) @(posedge aclk);
    #1 chk({25'h0, pins}, 32'h0000003E);
  endtask : t_gates
  task automatic tally_and_finish();
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (3) @(posedge aclk);
    {aresetn, por_n} <= 2'h3;
    t_defaults();
    t_writes();
    t_resets();
    t_gates();
    tally_and_finish();
  end
  initial begin
    repeat (2000) @(posedge aclk);
    fail_count++;
    tally_and_finish();
  end
endmodule : pm_misc_regs_test
bind pm_misc_regs pm_misc_regs_properties props_u (.*);
`default_nettype wire
